// [logic/fsa_defines.svh]
// constants for the flash status byte and array map block
`ifndef FSA_DEFINES_SVH
`define FSA_DEFINES_SVH
// status byte field positions
`define FSA_BIT_BUSY 0
`define FSA_BIT_WPL 1
`define FSA_BIT_PROT_LO 2
`define FSA_BIT_PROT_HI 5
`define FSA_BIT_QUAD 6
`define FSA_BIT_LOCK 7
`define FSA_STATUS_RESET 8'h00
// array map
`define FSA_SECTOR_BYTES 4096
`define FSA_SECTOR_COUNT 1024
`define FSA_ADDR_TOP 24'h3fffff
`define FSA_SECTOR_LSB 12
`define FSA_BLK32_LSB 15
`define FSA_BLK64_LSB 16
`define FSA_ADDR_MSB 21
// instruction codes
`define FSA_CMD_STATUS_WRITE 8'h01
`define FSA_CMD_STATUS_READ 8'h05
`define FSA_CMD_WRITE_PERMIT 8'h06
`define FSA_CMD_WRITE_REVOKE 8'h04
`define FSA_CMD_PAGE_PROG 8'h02
`define FSA_CMD_PAGE_PROG_Q 8'h32
`define FSA_CMD_SECTOR_ERASE 8'h20
`define FSA_CMD_SECTOR_ERASE_ALT 8'hd7
`define FSA_CMD_BLK32_ERASE 8'h52
`define FSA_CMD_BLK64_ERASE 8'hd8
`define FSA_CMD_CHIP_ERASE 8'hc7
`define FSA_CMD_CHIP_ERASE_ALT 8'h60
`define FSA_CMD_FUNC_READ 8'h48
`define FSA_CMD_EXT_READ 8'h81
`define FSA_CMD_SUSPEND 8'h75
`define FSA_CMD_RESUME 8'h7a
`define FSA_CMD_RESET_ARM 8'h66
`define FSA_CMD_RESET 8'h99
// timing
`define FSA_CLK_PERIOD_NS 10
`define FSA_OP_TIME_NS 10000
`define FSA_OP_CYCLES (`FSA_OP_TIME_NS / `FSA_CLK_PERIOD_NS)
`endif

// [logic/fsa_pkg.sv]
// types for the flash status byte and array map block
package fsa_pkg;
    typedef struct packed {
        logic status_lock_bit;
        logic four_lane_enable;
        logic [3:0] protect_level;
        logic write_permit_latch;
        logic operation_busy_flag;
    } fsa_status_t;

    typedef enum logic [1:0] {
        FSA_OP_PROG,
        FSA_OP_ERASE,
        FSA_OP_STATUS
    } fsa_op_t;

    typedef enum {
        FSA_ST_OPCODE,
        FSA_ST_ADDR,
        FSA_ST_WDATA,
        FSA_ST_RDOUT,
        FSA_ST_IGNORE
    } fsa_state_t;

    typedef struct packed {
        logic [9:0] sector;
        logic [6:0] blk32;
        logic [5:0] blk64;
    } fsa_map_t;
endpackage

// [logic/fsa_status_map.sv]
// flash status byte, instruction gate and array map behind the serial pins
//
// Functional notes
// R1 - array is 4 KB sectors, 32 KB blocks of eight, 64 KB blocks of sixteen
// R2 - sector n spans n*0x1000 to plus 0xfff, 1024 sectors to 3fffffh
// R3 - status byte: lock, quad, four protect bits, write permit, busy
// R4 - all status bits reset to zero, non-volatile bits start cleared
// R5 - busy bit is read-only, one during internal write, zero when ready
// R6 - busy set during program, erase or status write
// R7 - while busy only status/function/extended reads and resets are taken; code also takes suspend and, while suspended, resume
// R8 - suspend instruction still taken while program or erase runs
// R9 - busy cleared when operation ends, new instructions then accepted
// R10 - write permit changes only by permit and revoke instructions; code also clears it at operation end and on reset instruction
// R11 - protect, quad and lock bits change only by status write
// R12 - protect bits select write-protected blocks, zero protects nothing
// R13 - quad bit enables the four-lane data function
// R14 - lock bit one means status byte is write-protected
// R15 - status read instruction returns current status byte
// R16 - write permit set by permit, cleared when any write operation finishes
// R17 - lock one and guard pin low makes status write ignored
// R18 - with quad on, guard and pause pins act as data lanes two and three
// R19 - sector from bits 21:12, 32 KB block 21:15, 64 KB block 21:16
`timescale 1ns/100ps
`include "fsa_defines.svh"
module fsa_status_map #(
    parameter int OP_CYCLES = `FSA_OP_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic guard_n_lane_two,
    input wire logic pause_n_lane_three,
    output logic so,
    output logic so_oe,
    output fsa_pkg::fsa_status_t status_byte,
    output logic lanes_are_data,
    output logic op_start,
    output fsa_pkg::fsa_op_t op_kind,
    output logic [23:0] op_addr,
    output fsa_pkg::fsa_map_t op_map,
    output logic op_suspended
);
    // protection decode over 64 KB blocks
    function automatic logic prot_hit(input logic [3:0] lvl, input logic [5:0] blk);
        logic hit;
        hit = 1'b0;
        if (lvl >= 4'h1 && lvl <= 4'h6)
            hit = ({1'b0, blk} >= (7'h40 - (7'h01 << (lvl - 4'h1))));
        else if (lvl == 4'h7 || lvl == 4'h8)
            hit = 1'b1;
        else if (lvl >= 4'h9 && lvl <= 4'he)
            hit = ({1'b0, blk} < (7'h01 << (4'he - lvl)));
        return hit;
    endfunction

    // array map of an address
    function automatic fsa_pkg::fsa_map_t map_of(input logic [23:0] a);
        fsa_pkg::fsa_map_t m;
        m.sector = a[`FSA_ADDR_MSB:`FSA_SECTOR_LSB]; // R19 R2 R1
        m.blk32 = a[`FSA_ADDR_MSB:`FSA_BLK32_LSB]; // R19 R1
        m.blk64 = a[`FSA_ADDR_MSB:`FSA_BLK64_LSB]; // R19 R1
        return m;
    endfunction

    logic [2:0] sck_s;
    logic [2:0] cs_s;
    logic [1:0] si_s;
    logic [1:0] guard_s;
    logic [1:0] pause_s;
    fsa_pkg::fsa_status_t st;
    fsa_pkg::fsa_state_t state;
    logic [4:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] cmd;
    logic [23:0] addr;
    logic [7:0] wdata;
    logic [7:0] rd_sh;
    logic wdata_ok;
    logic [31:0] op_cnt;
    logic suspended;
    fsa_pkg::fsa_op_t kind;

    // synchronise the serial pins to the clock
    always_ff @(posedge clock)
    begin
        sck_s <= {sck_s[1:0], sck};
        cs_s <= {cs_s[1:0], cs_n};
        si_s <= {si_s[0], si};
        guard_s <= {guard_s[0], guard_n_lane_two};
        pause_s <= {pause_s[0], pause_n_lane_three};
    end

    // edge detection and pin function selection
    wire quad_on = st.four_lane_enable; // R13
    wire guard_low = ~quad_on & ~guard_s[1]; // R18
    wire paused = ~quad_on & ~pause_s[1]; // R18
    wire selected = ~cs_s[1];
    wire frame_end = cs_s[1] & ~cs_s[2];
    wire sck_rise = sck_s[1] & ~sck_s[2] & selected & ~paused;
    wire sck_fall = ~sck_s[1] & sck_s[2] & selected & ~paused;
    wire [7:0] next_byte = {shreg[6:0], si_s[1]};
    wire byte_done = sck_rise & (bit_cnt[2:0] == 3'h7);

    // opcode classes
    wire is_read_ok = next_byte == `FSA_CMD_STATUS_READ || next_byte == `FSA_CMD_FUNC_READ
        || next_byte == `FSA_CMD_EXT_READ;
    wire is_reset = next_byte == `FSA_CMD_RESET_ARM || next_byte == `FSA_CMD_RESET;
    wire is_addr_cmd = next_byte == `FSA_CMD_PAGE_PROG || next_byte == `FSA_CMD_PAGE_PROG_Q
        || next_byte == `FSA_CMD_SECTOR_ERASE || next_byte == `FSA_CMD_SECTOR_ERASE_ALT
        || next_byte == `FSA_CMD_BLK32_ERASE || next_byte == `FSA_CMD_BLK64_ERASE;
    wire is_chip = cmd == `FSA_CMD_CHIP_ERASE || cmd == `FSA_CMD_CHIP_ERASE_ALT;
    wire is_prog = cmd == `FSA_CMD_PAGE_PROG || cmd == `FSA_CMD_PAGE_PROG_Q;
    wire suspend_ok = next_byte == `FSA_CMD_SUSPEND && st.operation_busy_flag && !suspended
        && kind != fsa_pkg::FSA_OP_STATUS; // R8
    wire resume_ok = next_byte == `FSA_CMD_RESUME && suspended; // R8
    wire opcode_taken = !st.operation_busy_flag || is_read_ok || is_reset || suspend_ok || resume_ok; // R7

    // end-of-frame execution decisions
    wire in_opcode_done = state != fsa_pkg::FSA_ST_IGNORE;
    wire do_status_wr = frame_end && cmd == `FSA_CMD_STATUS_WRITE && wdata_ok && in_opcode_done
        && st.write_permit_latch && !(st.status_lock_bit && guard_low); // R17 R14
    wire do_array_op = frame_end && in_opcode_done && st.write_permit_latch
        && ((is_chip && state == fsa_pkg::FSA_ST_WDATA && st.protect_level == 4'h0)
        || (!is_chip && (state == fsa_pkg::FSA_ST_WDATA) && bit_cnt == 5'h00 && wdata_ok
        && !prot_hit(st.protect_level, addr[`FSA_ADDR_MSB:`FSA_BLK64_LSB]))); // R12
    wire op_finish = st.operation_busy_flag && !suspended && op_cnt == OP_CYCLES - 1;

    // serial command state machine
    always_ff @(posedge clock)
    begin
        if (rst || !selected)
        begin
            state <= fsa_pkg::FSA_ST_OPCODE;
            bit_cnt <= 5'h00;
            shreg <= 8'h00;
            wdata_ok <= 1'b0;
            if (rst)
            begin
                cmd <= 8'h00;
                addr <= 24'h000000;
                wdata <= 8'h00;
            end
        end
        else if (sck_rise)
        begin
            shreg <= next_byte;
            bit_cnt <= bit_cnt + 5'h01;
            case (state)
                fsa_pkg::FSA_ST_OPCODE:
                    if (byte_done)
                    begin
                        cmd <= next_byte;
                        bit_cnt <= 5'h00;
                        if (!opcode_taken)
                            state <= fsa_pkg::FSA_ST_IGNORE;
                        else if (is_read_ok)
                            state <= fsa_pkg::FSA_ST_RDOUT;
                        else if (is_addr_cmd)
                            state <= fsa_pkg::FSA_ST_ADDR;
                        else
                            state <= fsa_pkg::FSA_ST_WDATA;
                    end
                fsa_pkg::FSA_ST_ADDR:
                begin
                    addr <= {addr[22:0], si_s[1]};
                    if (bit_cnt == 5'h17)
                    begin
                        bit_cnt <= 5'h00;
                        wdata_ok <= 1'b1;
                        state <= fsa_pkg::FSA_ST_WDATA;
                    end
                end
                fsa_pkg::FSA_ST_WDATA:
                    if (byte_done && !wdata_ok)
                    begin
                        wdata <= next_byte;
                        wdata_ok <= 1'b1;
                    end
                fsa_pkg::FSA_ST_RDOUT:
                    state <= fsa_pkg::FSA_ST_RDOUT;
                fsa_pkg::FSA_ST_IGNORE:
                    state <= fsa_pkg::FSA_ST_IGNORE;
                default:
                    state <= fsa_pkg::FSA_ST_IGNORE;
            endcase
        end
    end

    // one-byte actions taken as the opcode completes
    wire cmd_now = selected && sck_rise && byte_done && state == fsa_pkg::FSA_ST_OPCODE && opcode_taken;
    wire permit_now = cmd_now && next_byte == `FSA_CMD_WRITE_PERMIT;
    wire revoke_now = cmd_now && next_byte == `FSA_CMD_WRITE_REVOKE;
    wire suspend_now = cmd_now && suspend_ok;
    wire resume_now = cmd_now && next_byte == `FSA_CMD_RESUME && suspended;
    wire reset_now = cmd_now && next_byte == `FSA_CMD_RESET;

    // status byte, busy timer and suspend
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            st <= `FSA_STATUS_RESET; // R4
            op_cnt <= 32'h0;
            suspended <= 1'b0;
            kind <= fsa_pkg::FSA_OP_PROG;
        end
        else
        begin
            if (reset_now)
            begin
                st.operation_busy_flag <= 1'b0;
                st.write_permit_latch <= 1'b0;
                op_cnt <= 32'h0;
            end
            else if (op_finish)
            begin
                st.operation_busy_flag <= 1'b0; // R9 R5
                st.write_permit_latch <= 1'b0; // R16
                op_cnt <= 32'h0;
            end
            else if (do_status_wr)
            begin
                st.status_lock_bit <= wdata[`FSA_BIT_LOCK]; // R11
                st.four_lane_enable <= wdata[`FSA_BIT_QUAD]; // R11
                st.protect_level <= wdata[`FSA_BIT_PROT_HI:`FSA_BIT_PROT_LO]; // R11 R10
                st.operation_busy_flag <= 1'b1; // R6
                kind <= fsa_pkg::FSA_OP_STATUS;
            end
            else if (do_array_op)
            begin
                st.operation_busy_flag <= 1'b1; // R6
                kind <= is_prog ? fsa_pkg::FSA_OP_PROG : fsa_pkg::FSA_OP_ERASE;
            end
            else if (permit_now)
                st.write_permit_latch <= 1'b1; // R10 R16
            else if (revoke_now)
                st.write_permit_latch <= 1'b0; // R10
            else if (st.operation_busy_flag && !suspended)
                op_cnt <= op_cnt + 32'h1;
            if (suspend_now && !op_finish)
                suspended <= 1'b1; // R8
            else if (resume_now || reset_now)
                suspended <= 1'b0;
        end
    end

    // read shifter: status byte goes out msb first on falling edges
    always_ff @(posedge clock)
    begin
        if (rst || !selected)
        begin
            rd_sh <= 8'h00;
            so <= 1'b0;
            so_oe <= 1'b0;
        end
        else
        begin
            so_oe <= state == fsa_pkg::FSA_ST_RDOUT && !paused;
            if (sck_fall && state == fsa_pkg::FSA_ST_RDOUT)
            begin
                if (bit_cnt[2:0] == 3'h0)
                begin
                    so <= (cmd == `FSA_CMD_STATUS_READ) ? st[7] : 1'b0; // R15
                    rd_sh <= (cmd == `FSA_CMD_STATUS_READ) ? {st[6:0], 1'b0} : 8'h00; // R15 R3
                end
                else
                begin
                    so <= rd_sh[7];
                    rd_sh <= {rd_sh[6:0], 1'b0};
                end
            end
        end
    end

    // registered outputs
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            status_byte <= `FSA_STATUS_RESET;
            lanes_are_data <= 1'b0;
            op_start <= 1'b0;
            op_kind <= fsa_pkg::FSA_OP_PROG;
            op_addr <= 24'h000000;
            op_map <= '0;
            op_suspended <= 1'b0;
        end
        else
        begin
            status_byte <= st; // R3
            lanes_are_data <= st.four_lane_enable; // R18
            op_start <= do_array_op;
            op_suspended <= suspended;
            if (do_array_op)
            begin
                op_kind <= is_prog ? fsa_pkg::FSA_OP_PROG : fsa_pkg::FSA_OP_ERASE;
                op_addr <= is_chip ? 24'h000000 : (addr & `FSA_ADDR_TOP); // R2
                op_map <= map_of(is_chip ? 24'h000000 : addr); // R19
            end
        end
    end
endmodule

// [tb/fsa_status_map_assertions.sv]
// port-level assertions for the flash status block
`timescale 1ns/100ps
module fsa_status_map_assertions #(
    parameter int OP_CYCLES = 1000
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic guard_n_lane_two,
    input wire logic pause_n_lane_three,
    input wire logic so,
    input wire logic so_oe,
    input fsa_pkg::fsa_status_t status_byte,
    input wire logic lanes_are_data,
    input wire logic op_start,
    input fsa_pkg::fsa_op_t op_kind,
    input wire logic [23:0] op_addr,
    input fsa_pkg::fsa_map_t op_map,
    input wire logic op_suspended
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    int busy_cnt;
    // busy cycles, frozen while suspended
    always_ff @(posedge clock)
    begin
        if (rst || !status_byte.operation_busy_flag)
            busy_cnt <= 0;
        else if (!op_suspended)
            busy_cnt <= busy_cnt + 1;
    end
    busy_bound_a: assert property (busy_cnt <= OP_CYCLES + 8)
        else $error("busy held past its operation time");
    map_fields_a: assert property (op_start |-> op_map.sector == op_addr[21:12] && op_map.blk32 == op_addr[21:15]
        && op_map.blk64 == op_addr[21:16]) else $error("map fields do not match address");
    start_busy_a: assert property (op_start |-> ##[0:4] status_byte.operation_busy_flag)
        else $error("launch without busy");
    start_permit_a: assert property (op_start |-> status_byte.write_permit_latch)
        else $error("launch without write permit");
    start_kind_a: assert property (op_start |-> op_kind != fsa_pkg::FSA_OP_STATUS)
        else $error("bad operation kind at launch");
    finish_clear_a: assert property ($fell(status_byte.operation_busy_flag) |-> !status_byte.write_permit_latch)
        else $error("permit left set after finish");
    permit_idle_a: assert property ($rose(status_byte.write_permit_latch) |-> !$past(status_byte.operation_busy_flag))
        else $error("permit taken while busy");
    nv_write_a: assert property ($changed(status_byte[7:2]) |-> ##[0:1] status_byte.operation_busy_flag)
        else $error("stored bits changed without a write cycle");
    lanes_mode_a: assert property ($stable(status_byte.four_lane_enable) |-> lanes_are_data
        == status_byte.four_lane_enable) else $error("lane mode differs from quad bit");
    idle_release_a: assert property (cs_n [*4] |-> !so_oe)
        else $error("output driven while deselected");
    launch_c: cover property (op_start);
    suspend_c: cover property ($rose(op_suspended));
    finish_c: cover property ($fell(status_byte.operation_busy_flag));
    quad_c: cover property ($rose(lanes_are_data));
endmodule
bind fsa_status_map fsa_status_map_assertions #(.OP_CYCLES(OP_CYCLES)) u_chk (.clock(clock), .rst(rst), .sck(sck),
    .cs_n(cs_n), .si(si), .guard_n_lane_two(guard_n_lane_two), .pause_n_lane_three(pause_n_lane_three), .so(so),
    .so_oe(so_oe), .status_byte(status_byte), .lanes_are_data(lanes_are_data), .op_start(op_start),
    .op_kind(op_kind), .op_addr(op_addr), .op_map(op_map), .op_suspended(op_suspended));

// [tb/fsa_host_model.sv]
// serial host controller issuing flash instructions
`timescale 1ns/100ps
module fsa_host_model (
    input wire logic clock,
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so
);
    logic [7:0] rx;
    // idle: deselected, clock low
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        rx = 8'h00;
    end
    // one frame, bytes msb first, 80 ns link clock
    task automatic frame(input logic [7:0] q[$]);
        @(posedge clock);
        cs_n <= 1'b0;
        foreach (q[k])
        begin
            for (int i = 7; i >= 0; i--)
            begin
                repeat (4) @(posedge clock);
                sck <= 1'b0;
                si <= q[k][i];
                repeat (4) @(posedge clock);
                sck <= 1'b1;
                rx <= {rx[6:0], so};
            end
        end
        repeat (4) @(posedge clock);
        sck <= 1'b0;
        repeat (4) @(posedge clock);
        cs_n <= 1'b1;
        si <= ~si; // released line, stale value inverted
        repeat (6) @(posedge clock);
    endtask
endmodule

// [tb/test_flash_status_and_array_map.sv]
// self-checking bench for the flash status block
`timescale 1ns/100ps
module test_flash_status_and_array_map;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic sck, cs_n, si, so, so_oe, lanes_are_data, op_start, op_suspended;
    logic guard_n_lane_two = 1'b1;
    logic pause_n_lane_three = 1'b1;
    fsa_pkg::fsa_status_t status_byte;
    fsa_pkg::fsa_op_t op_kind;
    fsa_pkg::fsa_map_t op_map;
    logic [23:0] op_addr;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    int n_starts = 0;
    always #5 clock = ~clock;
    fsa_host_model u_host (.clock(clock), .sck(sck), .cs_n(cs_n), .si(si), .so(so));
    fsa_status_map #(.OP_CYCLES(400)) u_dut (.clock(clock), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
        .guard_n_lane_two(guard_n_lane_two), .pause_n_lane_three(pause_n_lane_three), .so(so), .so_oe(so_oe),
        .status_byte(status_byte), .lanes_are_data(lanes_are_data), .op_start(op_start), .op_kind(op_kind),
        .op_addr(op_addr), .op_map(op_map), .op_suspended(op_suspended));
    // launch counter and run limit
    always @(posedge clock)
    begin
        cycles++;
        if (op_start === 1'b1)
            n_starts++;
        if (cycles == 40000)
        begin
            n_errors++;
            conclude();
        end
    end
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] exp);
        u_host.frame({8'h05, 8'h00});
        chk("status read", {16'h0000, exp}, {16'h0000, u_host.rx});
        chk("output enable idle", 24'h0, {23'h0, so_oe});
    endtask
    task automatic wait_ready();
        for (int i = 0; i < 2000 && status_byte.operation_busy_flag !== 1'b0; i++)
            @(posedge clock);
        #1;
        chk("busy after finish", 24'h0, {23'h0, status_byte.operation_busy_flag});
    endtask
    task automatic t_reset();
        chk("status port", 24'h0, {16'h0, status_byte});
        rd(8'h00);
    endtask
    task automatic t_permit();
        u_host.frame({8'h06});
        rd(8'h02);
        u_host.frame({8'h04});
        rd(8'h00);
    endtask
    task automatic t_status_write();
        u_host.frame({8'h06});
        u_host.frame({8'h01, 8'hbf});
        chk("busy on write", 24'h1, {23'h0, status_byte.operation_busy_flag});
        u_host.frame({8'h04});
        rd(8'hbf);
        wait_ready();
        rd(8'hbc);
    endtask
    task automatic t_lock();
        guard_n_lane_two <= 1'b0;
        u_host.frame({8'h06});
        u_host.frame({8'h01, 8'h00});
        chk("locked write busy", 24'h0, {23'h0, status_byte.operation_busy_flag});
        rd(8'hbe);
        guard_n_lane_two <= 1'b1;
        u_host.frame({8'h01, 8'h00});
        wait_ready();
        rd(8'h00);
    endtask
    task automatic t_map_suspend();
        int s;
        u_host.frame({8'h06});
        u_host.frame({8'h01, 8'h44});
        wait_ready();
        chk("lanes mode", 24'h1, {23'h0, lanes_are_data});
        s = n_starts;
        u_host.frame({8'h20, 8'h3e, 8'h12, 8'h34});
        chk("launch without permit", s, n_starts);
        u_host.frame({8'h06});
        u_host.frame({8'hd8, 8'h3f, 8'h00, 8'h00});
        chk("protected launch", s, n_starts);
        pause_n_lane_three <= 1'b0;
        rd(8'h46);
        pause_n_lane_three <= 1'b1;
        u_host.frame({8'h20, 8'h3e, 8'h12, 8'h34});
        chk("launch count", s + 1, n_starts);
        chk("op address", 24'h3e1234, op_addr);
        chk("op map", {1'b0, 10'h3e1, 7'h7c, 6'h3e}, {1'b0, op_map});
        chk("op kind", 24'h1, {22'h0, op_kind});
        u_host.frame({8'h75});
        repeat (500) @(posedge clock);
        #1;
        chk("suspended", 24'h1, {23'h0, op_suspended});
        chk("busy while suspended", 24'h1, {23'h0, status_byte.operation_busy_flag});
        u_host.frame({8'h7a});
        wait_ready();
        rd(8'h44);
    endtask
    task automatic t_chip_reset();
        int s;
        u_host.frame({8'h06});
        u_host.frame({8'hc7});
        chk("guarded chip erase", 24'h0, {23'h0, status_byte.operation_busy_flag});
        u_host.frame({8'h01, 8'h00});
        wait_ready();
        u_host.frame({8'h06});
        s = n_starts;
        u_host.frame({8'h60});
        chk("chip launch count", s + 1, n_starts);
        chk("chip op address", 24'h0, op_addr);
        chk("chip op kind", 24'h1, {22'h0, op_kind});
        rd(8'h03);
        u_host.frame({8'h99});
        chk("busy after reset", 24'h0, {23'h0, status_byte.operation_busy_flag});
        rd(8'h00);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // reset, then the scenarios in order
    initial
    begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
        t_reset();
        t_permit();
        t_status_write();
        t_lock();
        t_map_suspend();
        t_chip_reset();
        conclude();
    end
endmodule
